//--- logic/tkdc_pkg.sv
package tkdc_pkg;
    // startup times in ms, converted at 125 MHz
    localparam int unsigned CLK_KHZ = 125000;
    localparam int unsigned BOOT_NORMAL_MS = 110;
    localparam int unsigned BOOT_FIRST_MS = 2200;
    localparam int unsigned BOOT_BACKUP_MS = 140;
    localparam int unsigned BOOT_NORMAL_CYC = BOOT_NORMAL_MS * CLK_KHZ;
    localparam int unsigned BOOT_FIRST_CYC = BOOT_FIRST_MS * CLK_KHZ;
    localparam int unsigned BOOT_BACKUP_CYC = BOOT_BACKUP_MS * CLK_KHZ;
    localparam int unsigned CAL_MIN_SCANS = 11;
    localparam int unsigned CAL_MAX_SCANS = 62;
    localparam logic [7:0] CMD_FORCE_RESET = 8'h04;
    localparam logic [7:0] CMD_SLEEP = 8'h16;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_TIMEOUT = 8'h0C;
    localparam logic [7:0] REG_LIMITS = 8'h10;
    localparam logic [7:0] REG_CALBUSY = 8'h14;
    localparam logic [7:0] REG_CALERR = 8'h18;
    localparam logic [7:0] REG_ACTIVE = 8'h1C;
    // ctrl fields
    localparam int unsigned CTRL_SLEEP_EN_BIT = 0;
    localparam int unsigned CTRL_FIRST_BOOT_BIT = 1;
    localparam int unsigned CTRL_BACKUP_BIT = 2;
    localparam logic [31:0] TIMEOUT_RST = 32'h0000_0100;
    localparam logic [31:0] LIMITS_RST = 32'h0000_0305;

    typedef enum logic [2:0] {
        TK_BOOT = 3'b000,
        TK_CAL = 3'b001,
        TK_RUN = 3'b010,
        TK_SLEEP = 3'b011,
        TK_LOCK = 3'b100
    } tkdc_state_t;

    typedef struct packed {
        logic valid;
        logic [5:0] key;
        logic above;
        logic converged;
        logic last_key;
    } tkdc_acq_t;
endpackage

//--- logic/tkdc_top.sv
`timescale 1ns/100ps
// How it works
// - self-checks first; serial link enabled last, never after a fault
// - ordinary reset reaches link-ready after 110 ms
// - first power-up or settings recovery takes up to 2200 ms
// - settings backup at power-up takes 140 ms
// - after startup, every enabled key calibrates in parallel
// - calibration spans 11 to 62 scans, ends early on convergence
// - no convergence after 62 scans flags key calibration error
// - per-key calibrating bits of keys 0 to 31 readable by host
// - force-reset command acts as hardware reset while communicating
// - after lock-up only pin reset or power cycle recovers
// - per-key inner counter with limit, back-to-back bursts stall scan
// - outer counter steps on inner limit, once per scan
// - outer terminal count declares key active
// - sleep needs sleep setting and sleep command
// - low pulse on wake pin wakes device to scan
// - at least one full scan after wake before sleeping
// - end of scan: sleep unless recent activity, else rescan
// - no sleep while calibrating or touch in last scan
// - sleep disabled never sleeps; enabled sleeps after timeout
// - asleep halts all internal operation including check counters
module tkdc_top #(
    parameter int unsigned NKEYS = 48,
    parameter int unsigned BOOT_NORMAL = tkdc_pkg::BOOT_NORMAL_CYC,
    parameter int unsigned BOOT_FIRST = tkdc_pkg::BOOT_FIRST_CYC,
    parameter int unsigned BOOT_BACKUP = tkdc_pkg::BOOT_BACKUP_CYC
) (
    input wire logic CORE_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic RESET_PIN_N_IN,
    input wire logic WAKE_PULSE_INPUT_N_IN,
    input wire logic SELFTEST_FAIL_IN,
    input wire tkdc_pkg::tkdc_acq_t ACQ_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic LINK_EN_OUT,
    output logic REPEAT_BURST_OUT,
    output logic ACQ_RUN_OUT,
    output logic SLEEPING_OUT
);
    import tkdc_pkg::*;

    if (NKEYS < 1 || NKEYS > 64) begin : g_bad_nkeys
        $error("NKEYS out of range");
    end
    if (BOOT_NORMAL < 1 || BOOT_FIRST < 1
            || BOOT_BACKUP < 1) begin : g_bad_boot
        $error("boot counts must be positive");
    end

    // ***********************************************
    // input synchronisers and reset merge
    // ***********************************************
    logic [1:0] rpin_s_q;
    logic [1:0] wpin_s_q;
    logic wpin_d1_q;
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            rpin_s_q <= 2'h3;
            wpin_s_q <= 2'h3;
            wpin_d1_q <= 1'b1;
        end else begin
            rpin_s_q <= {rpin_s_q[0], RESET_PIN_N_IN};
            wpin_s_q <= {wpin_s_q[0], WAKE_PULSE_INPUT_N_IN};
            wpin_d1_q <= wpin_s_q[1];
        end
    end
    logic wake_fall;
    assign wake_fall = wpin_d1_q && !wpin_s_q[1];

    logic apb_wr;
    logic cmd_wr;
    logic soft_rst;
    logic sync_rst;
    tkdc_state_t state_q;
    assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign cmd_wr = apb_wr && PADDR_IN == REG_CMD;
    // no command acts once locked or before the link is up
    assign soft_rst = cmd_wr && PWDATA_IN[7:0] == CMD_FORCE_RESET
        && LINK_EN_OUT;
    // pin reset always wins, even in lock-up
    assign sync_rst = !rpin_s_q[1] || soft_rst;

    // ***********************************************
    // registers
    // ***********************************************
    logic [31:0] ctrl_q;
    logic [31:0] timeout_q;
    logic [31:0] limits_q;
    logic sleep_armed_q;
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ctrl_q <= 32'h0000_0000;
            timeout_q <= TIMEOUT_RST;
            limits_q <= LIMITS_RST;
        end else if (apb_wr && state_q != TK_LOCK) begin
            if (PADDR_IN == REG_CTRL) begin
                ctrl_q <= {29'h0, PWDATA_IN[2:0]};
            end else if (PADDR_IN == REG_TIMEOUT) begin
                timeout_q <= PWDATA_IN;
            end else if (PADDR_IN == REG_LIMITS) begin
                limits_q <= {16'h0, PWDATA_IN[15:0]};
            end
        end
    end
    logic sleep_en;
    logic [7:0] inner_lim;
    logic [7:0] outer_lim;
    assign sleep_en = ctrl_q[CTRL_SLEEP_EN_BIT];
    assign inner_lim = limits_q[7:0];
    assign outer_lim = limits_q[15:8];

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            sleep_armed_q <= 1'b0;
        end else if (sync_rst || !sleep_en) begin
            sleep_armed_q <= 1'b0;
        end else if (cmd_wr && LINK_EN_OUT
                && PWDATA_IN[7:0] == CMD_SLEEP) begin
            sleep_armed_q <= 1'b1;
        end
    end

    // ***********************************************
    // startup sequence
    // ***********************************************
    logic [31:0] boot_cnt_q;
    logic [31:0] boot_target;
    always_comb begin
        if (ctrl_q[CTRL_FIRST_BOOT_BIT]) begin
            boot_target = BOOT_FIRST;
        end else if (ctrl_q[CTRL_BACKUP_BIT]) begin
            boot_target = BOOT_BACKUP;
        end else begin
            boot_target = BOOT_NORMAL;
        end
    end

    logic [63:0] cal_busy_q;
    logic [63:0] cal_err_q;
    logic [63:0] active_q;
    logic [63:0] key_mask;
    logic scan_end;
    logic [31:0] idle_cnt_q;
    logic scan_touch_q;
    logic woke_scan_q;
    assign key_mask = (NKEYS == 64) ? {64{1'b1}}
        : ((64'h0000_0000_0000_0001 << NKEYS) - 64'h0000_0000_0000_0001);
    assign scan_end = ACQ_IN.valid && ACQ_IN.last_key
        && state_q != TK_SLEEP;

    logic may_sleep;
    assign may_sleep = sleep_en && sleep_armed_q && !woke_scan_q
        && cal_busy_q == 64'h0 && !scan_touch_q && !ACQ_IN.above
        && idle_cnt_q >= timeout_q;

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            state_q <= TK_BOOT;
            boot_cnt_q <= 32'h0;
        end else if (sync_rst) begin
            state_q <= TK_BOOT;
            boot_cnt_q <= 32'h0;
        end else begin
            case (state_q)
                TK_BOOT: begin
                    if (SELFTEST_FAIL_IN) begin
                        state_q <= TK_LOCK;
                    end else if (boot_cnt_q + 32'h1 >= boot_target) begin
                        state_q <= TK_CAL;
                    end else begin
                        boot_cnt_q <= boot_cnt_q + 32'h1;
                    end
                end
                TK_CAL, TK_RUN: begin
                    if (SELFTEST_FAIL_IN) begin
                        state_q <= TK_LOCK;
                    end else if (state_q == TK_CAL
                            && cal_busy_q == 64'h0) begin
                        state_q <= TK_RUN;
                    end else if (scan_end && state_q == TK_RUN
                            && may_sleep) begin
                        state_q <= TK_SLEEP;
                    end
                end
                TK_SLEEP: begin
                    if (wake_fall) begin
                        state_q <= TK_RUN;
                    end
                end
                default: state_q <= TK_LOCK;
            endcase
        end
    end

    // link comes up only after self-check passes
    assign LINK_EN_OUT = state_q == TK_CAL || state_q == TK_RUN
        || state_q == TK_SLEEP;
    // acquisition and check counters stop in sleep and lock
    assign ACQ_RUN_OUT = state_q == TK_CAL || state_q == TK_RUN;
    assign SLEEPING_OUT = state_q == TK_SLEEP;

    // ***********************************************
    // activity tracking for sleep
    // ***********************************************
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            woke_scan_q <= 1'b0;
            scan_touch_q <= 1'b0;
            idle_cnt_q <= 32'h0;
        end else if (sync_rst) begin
            woke_scan_q <= 1'b0;
            scan_touch_q <= 1'b0;
            idle_cnt_q <= 32'h0;
        end else begin
            if (state_q == TK_SLEEP && wake_fall) begin
                woke_scan_q <= 1'b1;
            end else if (scan_end) begin
                woke_scan_q <= 1'b0;
            end
            // touch seen anywhere in the scan so far
            if (scan_end) begin
                scan_touch_q <= 1'b0;
            end else if (ACQ_IN.valid && ACQ_IN.above && ACQ_RUN_OUT) begin
                scan_touch_q <= 1'b1;
            end
            if (ACQ_RUN_OUT && ACQ_IN.valid && ACQ_IN.above) begin
                idle_cnt_q <= 32'h0;
            end else if (ACQ_RUN_OUT && idle_cnt_q != 32'hFFFF_FFFF) begin
                idle_cnt_q <= idle_cnt_q + 32'h1;
            end
        end
    end

    // ***********************************************
    // per-key calibration and confirmation
    // ***********************************************
    logic [5:0] cal_scans_q [64];
    logic [7:0] inner_q [64];
    logic [7:0] outer_q [64];
    logic [63:0] outer_done_q;
    logic acq_ok;
    logic [5:0] k;
    assign acq_ok = ACQ_IN.valid && ACQ_RUN_OUT;
    assign k = ACQ_IN.key;

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            cal_busy_q <= 64'h0;
            cal_err_q <= 64'h0;
            for (int i = 0; i < 64; i++) begin
                cal_scans_q[i] <= 6'h0;
            end
        end else if (sync_rst || state_q == TK_BOOT) begin
            cal_busy_q <= key_mask;
            cal_err_q <= 64'h0;
            for (int i = 0; i < 64; i++) begin
                cal_scans_q[i] <= 6'h0;
            end
        end else if (acq_ok && cal_busy_q[k]) begin
            cal_scans_q[k] <= cal_scans_q[k] + 6'h1;
            if (ACQ_IN.converged
                    && cal_scans_q[k] + 6'h1 >= 6'(CAL_MIN_SCANS)) begin
                cal_busy_q[k] <= 1'b0;
            end else if (cal_scans_q[k] + 6'h1 >= 6'(CAL_MAX_SCANS)) begin
                cal_busy_q[k] <= 1'b0;
                cal_err_q[k] <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            active_q <= 64'h0;
            outer_done_q <= 64'h0;
            for (int i = 0; i < 64; i++) begin
                inner_q[i] <= 8'h0;
                outer_q[i] <= 8'h0;
            end
        end else if (sync_rst || state_q == TK_BOOT) begin
            active_q <= 64'h0;
            outer_done_q <= 64'h0;
            for (int i = 0; i < 64; i++) begin
                inner_q[i] <= 8'h0;
                outer_q[i] <= 8'h0;
            end
        end else begin
            if (scan_end) begin
                outer_done_q <= 64'h0;
            end
            if (acq_ok && !cal_busy_q[k]) begin
                if (!ACQ_IN.above) begin
                    inner_q[k] <= 8'h0;
                    outer_q[k] <= 8'h0;
                    active_q[k] <= 1'b0;
                end else if (inner_q[k] + 8'h1 >= inner_lim) begin
                    inner_q[k] <= 8'h0;
                    if (!outer_done_q[k]) begin
                        outer_done_q[k] <= !scan_end;
                        if (outer_q[k] + 8'h1 >= outer_lim) begin
                            active_q[k] <= 1'b1;
                        end else begin
                            outer_q[k] <= outer_q[k] + 8'h1;
                        end
                    end
                end else begin
                    inner_q[k] <= inner_q[k] + 8'h1;
                end
            end
        end
    end

    // ask acquisition to burst same key again while inner count runs
    assign REPEAT_BURST_OUT = acq_ok && !cal_busy_q[k] && ACQ_IN.above
        && inner_q[k] + 8'h1 < inner_lim;

    // ***********************************************
    // apb read side
    // ***********************************************
    assign PREADY_OUT = 1'b1;
    always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            PRDATA_OUT <= 32'h0;
            PSLVERR_OUT <= 1'b0;
        end else if (PSEL_IN && !PENABLE_IN) begin
            PSLVERR_OUT <= 1'b0;
            if (PADDR_IN == REG_CTRL) begin
                PRDATA_OUT <= ctrl_q;
            end else if (PADDR_IN == REG_STATUS) begin
                PRDATA_OUT <= {24'h0, sleep_armed_q, LINK_EN_OUT,
                    cal_err_q != 64'h0, 2'h0, state_q};
            end else if (PADDR_IN == REG_CMD) begin
                PRDATA_OUT <= 32'h0;
            end else if (PADDR_IN == REG_TIMEOUT) begin
                PRDATA_OUT <= timeout_q;
            end else if (PADDR_IN == REG_LIMITS) begin
                PRDATA_OUT <= limits_q;
            end else if (PADDR_IN == REG_CALBUSY) begin
                PRDATA_OUT <= cal_busy_q[31:0];
            end else if (PADDR_IN == REG_CALERR) begin
                PRDATA_OUT <= cal_err_q[31:0];
            end else if (PADDR_IN == REG_ACTIVE) begin
                PRDATA_OUT <= active_q[31:0];
            end else begin
                PRDATA_OUT <= 32'h0;
                PSLVERR_OUT <= 1'b1;
            end
        end
    end

    // ***********************************************
    // assertions
    // ***********************************************
    property p_lock_silent;
        @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        state_q == TK_LOCK && rpin_s_q[1] |=> state_q == TK_LOCK;
    endproperty
    a_lock_silent: assert property (p_lock_silent)
        else $error("lock-up left without pin reset");

    property p_link_gate;
        @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        $rose(LINK_EN_OUT) |-> $past(state_q) == TK_BOOT
            && !$past(SELFTEST_FAIL_IN)
            && $past(boot_cnt_q) + 32'h1 >= $past(boot_target);
    endproperty
    a_link_gate: assert property (p_link_gate)
        else $error("link enabled before self-check");

    property p_sleep_halts;
        @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        SLEEPING_OUT && !sync_rst |=> $stable(idle_cnt_q)
            && $stable(cal_busy_q) && $stable(active_q);
    endproperty
    a_sleep_halts: assert property (p_sleep_halts)
        else $error("acquisition running while asleep");

    property p_no_sleep_cal;
        @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        $rose(SLEEPING_OUT) |-> $past(cal_busy_q) == 64'h0
            && $past(sleep_armed_q) && $past(sleep_en);
    endproperty
    a_no_sleep_cal: assert property (p_no_sleep_cal)
        else $error("slept while calibrating or not armed");

    sequence s_woke;
        state_q == TK_SLEEP && wake_fall && !sync_rst;
    endsequence
    property p_wake_scan;
        @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        s_woke |=> state_q == TK_RUN && woke_scan_q;
    endproperty
    a_wake_scan: assert property (p_wake_scan)
        else $error("wake pulse did not start a scan");

    property p_force_reset;
        @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        soft_rst |=> state_q == TK_BOOT && boot_cnt_q == 32'h0;
    endproperty
    a_force_reset: assert property (p_force_reset)
        else $error("force reset command ignored");

    property p_boot_time;
        @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        state_q == TK_BOOT && $past(state_q) == TK_BOOT && !sync_rst
            && !SELFTEST_FAIL_IN && boot_cnt_q + 32'h1 >= boot_target
            |=> state_q == TK_CAL;
    endproperty
    a_boot_time: assert property (p_boot_time)
        else $error("startup did not end on time");

    property p_cal_err;
        @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
        $rose(cal_err_q[0]) |-> $past(cal_scans_q[0]) == 6'd61;
    endproperty
    a_cal_err: assert property (p_cal_err)
        else $error("calibration error at wrong scan count");
endmodule

//--- bench/tkdc_acq_model.sv
`timescale 1ns/100ps
// ****************************************
// acquisition front end: one key per sample
// ****************************************
module tkdc_acq_model #(
    parameter int unsigned NK = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic repeat_in,
    input wire logic [3:0] above_in,
    input wire logic [3:0] conv_in,
    output tkdc_pkg::tkdc_acq_t acq_out
);
    import tkdc_pkg::*;
    logic valid_q;
    logic [5:0] key_q;
    logic lst;
    logic ab;
    logic cv;
    assign lst = (key_q == 6'(NK - 1));
    assign ab = above_in[key_q[1:0]];
    assign cv = conv_in[key_q[1:0]];
    // between samples the fields are inverted, never stale
    always_comb begin
        if (valid_q) begin
            acq_out = '{1'b1, key_q, ab, cv, lst};
        end else begin
            acq_out = '{1'b0, ~key_q, ~ab, ~cv, ~lst};
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            valid_q <= 1'b0;
            key_q <= 6'h00;
        end else if (!run_in) begin
            valid_q <= 1'b0;
        end else if (!valid_q) begin
            valid_q <= 1'b1;
        end else begin
            valid_q <= 1'b0;
            // burst request keeps the same key
            if (!repeat_in) begin
                key_q <= lst ? 6'h00 : key_q + 6'h01;
            end
        end
    end
endmodule

//--- bench/tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    n_errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
    end end
module tb;
    import tkdc_pkg::*;
    localparam int NB = 20;
    localparam int NF = 40;
    localparam int NU = 30;
    typedef struct {logic [31:0] ctrl; int boot;} tkdc_row_t;
    logic clk = 0, rst_n = 0, pin_n = 1, wake_n = 1, fail = 0;
    logic psel = 0, pen = 0, pwr = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, link, rep, run, slp;
    logic [3:0] above = 4'h0, conv = 4'hE;
    tkdc_acq_t acq;
    int n_errors = 0, n_compared = 0, n_scans = 0, n_cyc = 0, n_rep = 0;
    int c, s;
    tkdc_row_t rows[3] = '{'{32'h0000_0002, NF},
        '{32'h0000_0004, NU},
        '{32'h0000_0000, NB}};
    tkdc_top #(.NKEYS(4), .BOOT_NORMAL(NB), .BOOT_FIRST(NF),
        .BOOT_BACKUP(NU)) u_tkdc_top (.CORE_CLK_IN(clk), .RSTN_IN(rst_n),
        .RESET_PIN_N_IN(pin_n), .WAKE_PULSE_INPUT_N_IN(wake_n),
        .SELFTEST_FAIL_IN(fail), .ACQ_IN(acq), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .LINK_EN_OUT(link),
        .REPEAT_BURST_OUT(rep), .ACQ_RUN_OUT(run), .SLEEPING_OUT(slp));
    tkdc_acq_model #(.NK(4)) u_tkdc_acq_model (.clk_in(clk),
        .rst_n_in(rst_n), .run_in(run), .repeat_in(rep),
        .above_in(above), .conv_in(conv), .acq_out(acq));
    // ****************************************
    // clock, scan counting, hang guard
    // ****************************************
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        n_cyc <= n_cyc + 1;
        if (acq.valid && acq.last_key && !rep) n_scans <= n_scans + 1;
        if (rep === 1'b1) n_rep <= n_rep + 1;
        if (n_cyc >= 40000) begin
            n_errors++;
            finish_test();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task finish_test;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task pin_reset;
        pin_n <= 1'b0;
        repeat (1300) @(posedge clk);
        pin_n <= 1'b1;
    endtask
    task wake;
        wake_n <= 1'b0;
        repeat (4) @(posedge clk);
        wake_n <= 1'b1;
    endtask
    task boot_check(input int b);
        c = 0;
        while (link !== 1'b1 && c < 5000) begin
            @(posedge clk);
            c++;
        end
        `CHK("boot", 1'b1, (c >= b - 6 && c <= b + 6))
    endtask
    task wait_scans(input int n);
        s = n_scans + n;
        while (n_scans < s) @(posedge clk);
    endtask
    task wait_sleep(input logic v, input int n);
        c = 0;
        while (slp !== v && c < n) begin
            @(posedge clk);
            c++;
        end
    endtask
    task count_sleep(input int n);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            if (slp !== 1'b0) c++;
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        boot_check(NB);
        apb(0, REG_TIMEOUT, 0);
        `CHK("timeout rst", TIMEOUT_RST, rd)
        apb(0, REG_LIMITS, 0);
        `CHK("limits rst", LIMITS_RST, rd)
        apb(0, 8'h40, 0);
        `CHK("unmapped", 1'b1, er)
        apb(0, REG_CALBUSY, 0);
        `CHK("cal busy", 4'hF, rd[3:0])
        wait_scans(6);
        apb(0, REG_CALBUSY, 0);
        `CHK("cal min", 4'hF, rd[3:0])
        wait_scans(10);
        apb(0, REG_CALBUSY, 0);
        `CHK("cal early", 4'h1, rd[3:0])
        wait_scans(50);
        apb(0, REG_CALERR, 0);
        `CHK("cal err", 4'h1, rd[3:0])
        conv <= 4'hF;
        foreach (rows[i]) begin
            apb(1, REG_CTRL, rows[i].ctrl);
            pin_reset();
            boot_check(rows[i].boot);
        end
        wait_scans(14);
        apb(0, REG_CALBUSY, 0);
        `CHK("cal done", 4'h0, rd[3:0])
        above <= 4'h2;
        wait_scans(1);
        apb(0, REG_ACTIVE, 0);
        `CHK("not yet", 4'h0, rd[3:0])
        wait_scans(5);
        apb(0, REG_ACTIVE, 0);
        `CHK("active", 4'h2, rd[3:0])
        `CHK("bursts", 1'b1, (n_rep > 0))
        above <= 4'h0;
        wait_scans(2);
        apb(0, REG_ACTIVE, 0);
        `CHK("released", 4'h0, rd[3:0])
        apb(1, REG_TIMEOUT, 32'h0000_0008);
        apb(1, REG_CTRL, 32'h0000_0001);
        count_sleep(300);
        `CHK("no cmd", 0, c)
        apb(1, REG_CMD, {24'h00_0000, CMD_SLEEP});
        wait_sleep(1'b1, 600);
        `CHK("asleep", 1'b1, slp)
        s = n_scans;
        repeat (60) @(posedge clk);
        `CHK("halted", 1'b0, run)
        `CHK("no scan", s, n_scans)
        wake();
        s = n_scans;
        wait_sleep(1'b0, 20);
        `CHK("woken", 1'b0, slp)
        wait_sleep(1'b1, 600);
        `CHK("resleep", 1'b1, slp)
        `CHK("one scan", 1'b1, (n_scans - s >= 1))
        above <= 4'h2;
        wake();
        count_sleep(400);
        `CHK("touch inactivity_timeout", 0, c)
        above <= 4'h0;
        wait_sleep(1'b1, 900);
        `CHK("idle sleep", 1'b1, slp)
        wake();
        apb(1, REG_CTRL, 32'h0000_0000);
        count_sleep(400);
        `CHK("disabled", 0, c)
        apb(1, REG_CMD, {24'h00_0000, CMD_FORCE_RESET});
        `CHK("force rst", 1'b0, link)
        boot_check(NB);
        pin_reset();
        repeat (4) @(posedge clk);
        fail <= 1'b1;
        @(posedge clk);
        fail <= 1'b0;
        repeat (100) @(posedge clk);
        `CHK("lock link", 1'b0, link)
        apb(0, REG_STATUS, 0);
        `CHK("lock state", TK_LOCK, rd[2:0])
        apb(1, REG_CMD, {24'h00_0000, CMD_FORCE_RESET});
        repeat (100) @(posedge clk);
        `CHK("cmd ignored", 1'b0, link)
        pin_reset();
        boot_check(NB);
        finish_test();
    end
endmodule
